// file: hw/fsg_frame_sync.sv
// frame sync generator top: register port, generator, external relay
// assumes a byte-wide register port driven by the control interface
`timescale 1ns/100ps
`default_nettype none
module fsg_frame_sync
    import fsg_pkg::*;
#(
    parameter int PORTS = 2,
    parameter int SLOTS = 4
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic reg_write,
    input wire logic [7:0] reg_address,
    input wire logic [7:0] reg_write_data,
    output logic [7:0] reg_read_data,
    input wire logic [FSG_PIN_COUNT-1:0] gpio_in,
    output logic [PORTS-1:0][SLOTS-1:0] backchan_gpio_slot,
    output logic frame_sync
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [7:0] sync_control;
        logic [7:0] sync_high_count_upper;
        logic [7:0] sync_high_count_lower;
        logic [7:0] sync_low_count_upper;
        logic [7:0] sync_low_count_lower;
        logic [PORTS-1:0] port_select;
        logic [PORTS-1:0][2:0] backchan_rate_select;
        logic [PORTS-1:0][7:0] backchan_gpio_route_a;
        logic [PORTS-1:0][7:0] backchan_gpio_route_b;
        logic [FSG_TICK_WIDTH-1:0] tick_count;
        logic level;
        logic running;
        logic relay;
        logic [PORTS-1:0][SLOTS-1:0] slots;
        logic [7:0] read_data;
    } fsg_state_t;
    fsg_state_t state, next_state;

    logic [PORTS-1:0] port_tick;
    logic generator_enable, waveform_select, initial_level;
    logic [3:0] sync_source_select;
    logic [FSG_TICK_WIDTH-1:0] high_count, low_count, target;
    logic generator_tick, frame_tick, ext_mode, ext_pin, sync_value;
    logic [3:0] pin_index;

    // ****************************************
    // per-port tick dividers
    // ****************************************
    for (genvar p = 0; p < PORTS; p++) begin : g_port
        fsg_tick_if tick_bus ();
        assign tick_bus.rate = state.backchan_rate_select[p];
        assign port_tick[p] = tick_bus.tick;
        fsg_tick_divider u_fsg_tick_divider (
            .clock(clock),
            .reset(reset),
            .tick_port(tick_bus)
        );
    end

    assign generator_enable = state.sync_control[FSG_BIT_ENABLE];
    assign waveform_select = state.sync_control[FSG_BIT_WAVEFORM];
    assign initial_level = state.sync_control[FSG_BIT_INIT_LEVEL];
    assign sync_source_select =
        state.sync_control[FSG_SOURCE_MSB:FSG_SOURCE_LSB];
    assign high_count = {state.sync_high_count_upper,
        state.sync_high_count_lower};
    assign low_count = {state.sync_low_count_upper,
        state.sync_low_count_lower};
    assign pin_index = sync_source_select - FSG_SOURCE_PIN_FIRST;
    assign ext_mode = !generator_enable &&
        sync_source_select >= FSG_SOURCE_PIN_FIRST &&
        sync_source_select <= FSG_SOURCE_PIN_LAST;
    assign ext_pin = ext_mode ? gpio_in[pin_index[2:0]] : 1'b0;
    // tick source: port 1 by code 1, otherwise port 0
    assign generator_tick = (sync_source_select == FSG_SOURCE_PORT1 &&
        PORTS > 1) ? port_tick[PORTS-1] : port_tick[0];
    assign frame_tick = port_tick[0];
    assign sync_value = generator_enable ? state.level : state.relay;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_state = state;
        // square wave uses the high count for both halves
        if (waveform_select) begin
            target = high_count;
        end else begin
            target = state.level ? high_count : low_count;
        end
        // register writes, per-port registers to the selected ports only
        if (reg_write) begin
            case (reg_address)
                FSG_ADDR_CONTROL: next_state.sync_control = reg_write_data;
                FSG_ADDR_HIGH_UPPER:
                    next_state.sync_high_count_upper = reg_write_data;
                FSG_ADDR_HIGH_LOWER:
                    next_state.sync_high_count_lower = reg_write_data;
                FSG_ADDR_LOW_UPPER:
                    next_state.sync_low_count_upper = reg_write_data;
                FSG_ADDR_LOW_LOWER:
                    next_state.sync_low_count_lower = reg_write_data;
                FSG_ADDR_PORT_SELECT:
                    next_state.port_select = reg_write_data[PORTS-1:0];
                default: ;
            endcase
            for (int p = 0; p < PORTS; p++) begin
                if (state.port_select[p]) begin
                    if (reg_address == FSG_ADDR_RATE_SELECT) begin
                        next_state.backchan_rate_select[p] =
                            reg_write_data[2:0];
                    end
                    if (reg_address == FSG_ADDR_GPIO_ROUTE_A) begin
                        next_state.backchan_gpio_route_a[p] =
                            reg_write_data;
                    end
                    if (reg_address == FSG_ADDR_GPIO_ROUTE_B) begin
                        next_state.backchan_gpio_route_b[p] =
                            reg_write_data;
                    end
                end
            end
        end
        // internal generator
        if (!generator_enable) begin
            next_state.running = 1'b0;
            next_state.tick_count = '0;
            next_state.level = initial_level;
        end else if (!state.running) begin
            next_state.running = 1'b1;
            next_state.tick_count = '0;
            next_state.level = initial_level;
        end else if (generator_tick) begin
            if (state.tick_count >= target) begin
                next_state.tick_count = '0;
                next_state.level = !state.level;
            end else begin
                next_state.tick_count = state.tick_count + 1'b1;
            end
        end
        // external relay sampled once per back-channel frame
        if (frame_tick) begin
            next_state.relay = ext_pin;
        end
        // slot insertion, same sync value on every routed slot of every port, unrouted slots 0
        for (int p = 0; p < PORTS; p++) begin
            for (int s = 0; s < SLOTS; s++) begin
                logic [3:0] sel;
                sel = (s < 2) ? state.backchan_gpio_route_a[p][s*4 +: 4]
                    : state.backchan_gpio_route_b[p][(s-2)*4 +: 4];
                next_state.slots[p][s] = (sel == FSG_ROUTE_FRAME_SYNC)
                    ? sync_value : 1'b0;
            end
        end
        // read back, port 0 if selected, otherwise the last port, for per-port registers
        case (reg_address)
            FSG_ADDR_CONTROL: next_state.read_data = state.sync_control;
            FSG_ADDR_HIGH_UPPER:
                next_state.read_data = state.sync_high_count_upper;
            FSG_ADDR_HIGH_LOWER:
                next_state.read_data = state.sync_high_count_lower;
            FSG_ADDR_LOW_UPPER:
                next_state.read_data = state.sync_low_count_upper;
            FSG_ADDR_LOW_LOWER:
                next_state.read_data = state.sync_low_count_lower;
            FSG_ADDR_PORT_SELECT:
                next_state.read_data = 8'(state.port_select);
            FSG_ADDR_RATE_SELECT: next_state.read_data =
                {5'h00, state.backchan_rate_select[state.port_select[0]
                    ? 0 : PORTS-1]};
            FSG_ADDR_GPIO_ROUTE_A: next_state.read_data =
                state.backchan_gpio_route_a[state.port_select[0]
                    ? 0 : PORTS-1];
            FSG_ADDR_GPIO_ROUTE_B: next_state.read_data =
                state.backchan_gpio_route_b[state.port_select[0]
                    ? 0 : PORTS-1];
            default: next_state.read_data = FSG_READ_UNMAPPED;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state <= '0;
            state.port_select <= PORTS'(1);
            state.backchan_rate_select <= {PORTS{FSG_RATE_50MBPS}};
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign reg_read_data = state.read_data;
    assign backchan_gpio_slot = state.slots;
    assign frame_sync = sync_value;

    // ****************************************
    // checks: generator
    // ****************************************
    a_disable_restores:
        assert property (@(posedge clock) disable iff (reset)
        !generator_enable ##1 !generator_enable |->
        state.tick_count == '0 && state.level == $past(initial_level))
        else $error("disabled generator not at initial level");
    a_start_level:
        assert property (@(posedge clock) disable iff (reset)
        $rose(state.running) |-> state.level == $past(initial_level))
        else $error("wrong starting level");
    a_hold_count:
        assert property (@(posedge clock) disable iff (reset)
        state.running && generator_enable && generator_tick &&
        state.tick_count < target |=> state.level == $past(state.level))
        else $error("level toggled before count expired");
    a_toggle_expire:
        assert property (@(posedge clock) disable iff (reset)
        state.running && generator_enable && generator_tick &&
        state.tick_count >= target |=> state.level != $past(state.level))
        else $error("level failed to toggle");
    a_tick_paced:
        assert property (@(posedge clock) disable iff (reset)
        state.running && generator_enable && !generator_tick |=>
        state.level == $past(state.level) &&
        state.tick_count == $past(state.tick_count))
        else $error("generator moved without a tick");
    a_square_halves:
        assert property (@(posedge clock) disable iff (reset)
        state.running && generator_enable && waveform_select &&
        generator_tick && state.tick_count >= high_count |=>
        state.level != $past(state.level))
        else $error("square wave half not set by high count");
    a_enable_run:
        assert property (@(posedge clock) disable iff (reset)
        generator_enable ##1 generator_enable |-> state.running)
        else $error("generator not running");

    // ****************************************
    // checks: routing and relay
    // ****************************************
    a_ports_equal:
        assert property (@(posedge clock) disable iff (reset)
        PORTS > 1 && state.slots[0][0] != state.slots[PORTS-1][0] |->
        $past(state.backchan_gpio_route_a[0][3:0]) !=
        $past(state.backchan_gpio_route_a[PORTS-1][3:0]))
        else $error("ports carry different sync");
    a_slot_follows:
        assert property (@(posedge clock) disable iff (reset)
        state.backchan_gpio_route_a[0][3:0] == FSG_ROUTE_FRAME_SYNC |=>
        state.slots[0][0] == $past(sync_value))
        else $error("routed slot lost the sync value");
    a_route_gate:
        assert property (@(posedge clock) disable iff (reset)
        state.backchan_gpio_route_a[0][3:0] != FSG_ROUTE_FRAME_SYNC ##1
        state.backchan_gpio_route_a[0][3:0] != FSG_ROUTE_FRAME_SYNC
        |-> !state.slots[0][0])
        else $error("slot carries sync without route");
    a_route_write:
        assert property (@(posedge clock) disable iff (reset)
        reg_write && reg_address == FSG_ADDR_GPIO_ROUTE_A &&
        state.port_select[0] |=> state.backchan_gpio_route_a[0] ==
        $past(reg_write_data))
        else $error("route write lost");
    a_rate_write:
        assert property (@(posedge clock) disable iff (reset)
        reg_write && reg_address == FSG_ADDR_RATE_SELECT &&
        state.port_select[0] |=> state.backchan_rate_select[0] ==
        $past(reg_write_data[2:0]))
        else $error("rate write lost");
    a_ext_relay:
        assert property (@(posedge clock) disable iff (reset)
        frame_tick && !generator_enable |=> state.relay == $past(ext_pin))
        else $error("external pin not relayed");
    a_ext_off:
        assert property (@(posedge clock) disable iff (reset)
        frame_tick && generator_enable |=> !state.relay)
        else $error("pin relayed while generator on");
    a_relay_hold:
        assert property (@(posedge clock) disable iff (reset)
        !frame_tick |=> state.relay == $past(state.relay))
        else $error("relay changed between frame ticks");
endmodule
`default_nettype wire

// file: hw/fsg_pkg.sv
// frame sync generator package: register map, fields, timing constants
// assumes a register port with byte address and byte data
package fsg_pkg;
    localparam logic [7:0] FSG_ADDR_CONTROL = 8'h18;
    localparam logic [7:0] FSG_ADDR_HIGH_UPPER = 8'h19;
    localparam logic [7:0] FSG_ADDR_HIGH_LOWER = 8'h1A;
    localparam logic [7:0] FSG_ADDR_LOW_UPPER = 8'h1B;
    localparam logic [7:0] FSG_ADDR_LOW_LOWER = 8'h1C;
    localparam logic [7:0] FSG_ADDR_RATE_SELECT = 8'h58;
    localparam logic [7:0] FSG_ADDR_GPIO_ROUTE_A = 8'h6E;
    localparam logic [7:0] FSG_ADDR_GPIO_ROUTE_B = 8'h6F;
    localparam logic [7:0] FSG_ADDR_PORT_SELECT = 8'h4C;
    localparam logic [7:0] FSG_RESET_BYTE = 8'h00;
    localparam logic [7:0] FSG_READ_UNMAPPED = 8'h00;
    localparam int FSG_BIT_ENABLE = 0;
    localparam int FSG_BIT_WAVEFORM = 1;
    localparam int FSG_BIT_INIT_LEVEL = 2;
    localparam int FSG_SOURCE_MSB = 7;
    localparam int FSG_SOURCE_LSB = 4;
    localparam logic [3:0] FSG_SOURCE_PORT0 = 4'h0;
    localparam logic [3:0] FSG_SOURCE_PORT1 = 4'h1;
    localparam logic [3:0] FSG_SOURCE_PIN_FIRST = 4'h8;
    localparam logic [3:0] FSG_SOURCE_PIN_LAST = 4'hE;
    localparam logic [3:0] FSG_ROUTE_FRAME_SYNC = 4'hA;
    localparam logic [2:0] FSG_RATE_50MBPS = 3'h6;
    localparam int FSG_FRAME_BITS = 30;
    localparam int FSG_CLOCK_NS = 40;
    localparam int FSG_BIT_NS_50MBPS = 20;
    localparam int FSG_TICK_NS_50MBPS = FSG_FRAME_BITS * FSG_BIT_NS_50MBPS;
    localparam int FSG_TICK_CYCLES_50MBPS =
        (FSG_TICK_NS_50MBPS + FSG_CLOCK_NS - 1) / FSG_CLOCK_NS;
    localparam int FSG_TICK_WIDTH = 16;
    localparam int FSG_PIN_COUNT = 7;
endpackage

// file: hw/fsg_tick_divider.sv
// back-channel frame period tick divider for one link port
// assumes clock is the 25 MHz reference
`timescale 1ns/100ps
`default_nettype none
module fsg_tick_divider
    import fsg_pkg::*;
#(
    parameter int BASE_CYCLES = FSG_TICK_CYCLES_50MBPS
) (
    input wire logic clock,
    input wire logic reset,
    fsg_tick_if.divider tick_port
);
    typedef struct packed {
        logic [FSG_TICK_WIDTH-1:0] count;
        logic tick;
    } fsg_div_state_t;
    fsg_div_state_t state, next_state;
    logic [FSG_TICK_WIDTH-1:0] limit;

    always_comb begin
        // lower rate codes halve the rate per step below 50 Mbps
        limit = FSG_TICK_WIDTH'((BASE_CYCLES <<
            (FSG_RATE_50MBPS - tick_port.rate)) - 1);
        if (tick_port.rate > FSG_RATE_50MBPS) begin
            limit = FSG_TICK_WIDTH'(BASE_CYCLES - 1);
        end
        next_state = state;
        next_state.tick = 1'b0;
        if (state.count >= limit) begin
            next_state.count = '0;
            next_state.tick = 1'b1;
        end else begin
            next_state.count = state.count + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
    assign tick_port.tick = state.tick;

    a_tick_single:
        assert property (@(posedge clock) disable iff (reset)
        state.tick |=> !state.tick) else $error("tick longer than a cycle");
endmodule
`default_nettype wire

// file: hw/fsg_tick_if.sv
// tick bundle between the frame sync top and its tick divider
// assumes one clock domain
`timescale 1ns/100ps
`default_nettype none
interface fsg_tick_if;
    logic [2:0] rate;
    logic tick;
    modport divider (input rate, output tick);
    modport user (output rate, input tick);
endinterface
`default_nettype wire

// file: test/fsg_serializer_model.sv
// remote serializer model: receives one port's back-channel slots
// assumes slot values change only on the hub clock edge
`timescale 1ns/100ps
`default_nettype none
module fsg_serializer_model (
    input wire logic clock,
    input wire logic reset,
    input wire logic [3:0] slot,
    output logic [15:0] high_len,
    output logic [15:0] low_len
);
    logic prev;
    logic [15:0] run;
    // run lengths of the sync level carried in slot 0
    always @(posedge clock) begin
        if (reset) begin
            prev <= 1'b0;
            run <= 16'h0000;
            high_len <= 16'h0000;
            low_len <= 16'h0000;
        end else if (slot[0] !== prev) begin
            if (prev) begin
                high_len <= run;
            end else begin
                low_len <= run;
            end
            run <= 16'h0001;
            prev <= slot[0];
        end else begin
            run <= run + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// file: test/test_frame_sync_generator.sv
// testbench for the frame sync generator
// assumes the register port and timing of the generator top
`timescale 1ns/100ps
`default_nettype none
module test_frame_sync_generator
    import fsg_pkg::*;
;
    localparam int T = FSG_TICK_CYCLES_50MBPS;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic reg_write = 1'b0;
    logic [7:0] reg_address = 8'h00;
    logic [7:0] reg_write_data = 8'h00;
    logic [7:0] reg_read_data;
    logic [FSG_PIN_COUNT-1:0] gpio_in = '0;
    logic [1:0][3:0] backchan_gpio_slot;
    logic frame_sync;
    logic [15:0] high_len;
    logic [15:0] low_len;
    int miscompares = 0;
    int checks_done = 0;
    int n;
    logic differ;

    // nominal 25 MHz reference, so counts need no scaling
    always #20 clock = ~clock;

    fsg_frame_sync u_fsg_frame_sync (
        .clock(clock), .reset(reset), .reg_write(reg_write),
        .reg_address(reg_address), .reg_write_data(reg_write_data),
        .reg_read_data(reg_read_data), .gpio_in(gpio_in),
        .backchan_gpio_slot(backchan_gpio_slot), .frame_sync(frame_sync)
    );

    fsg_serializer_model u_fsg_serializer_model (
        .clock(clock), .reset(reset), .slot(backchan_gpio_slot[0]),
        .high_len(high_len), .low_len(low_len)
    );

    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clock);
        #1;
        reg_write = 1'b1;
        reg_address = addr;
        reg_write_data = data;
        @(posedge clock);
        #1;
        reg_write = 1'b0;
    endtask

    task automatic read_reg(input logic [7:0] addr, input logic [7:0] exp,
                            input string what);
        @(posedge clock);
        #1;
        reg_address = addr;
        @(posedge clock);
        #1;
        check(what, {8'h00, exp}, {8'h00, reg_read_data});
    endtask

    task automatic wait_fs(input logic level, input int limit,
                           output int cycles);
        cycles = 0;
        while (frame_sync !== level && cycles < limit) begin
            @(posedge clock);
            #1;
            cycles++;
        end
    endtask

    // cycles spent at one level over a whole run of it
    task automatic width(input logic level, output int cycles);
        int dummy;
        wait_fs(!level, 4000, dummy);
        wait_fs(level, 4000, dummy);
        wait_fs(!level, 4000, cycles);
    endtask

    task automatic watch(input int span, input int what);
        differ = 1'b0;
        repeat (span) begin
            @(posedge clock);
            #1;
            if (what == 0 && backchan_gpio_slot !== '0) differ = 1'b1;
            if (what == 1 && backchan_gpio_slot[1][1:0]
                !== backchan_gpio_slot[0][1:0]) differ = 1'b1;
            if (what == 2 && frame_sync !== 1'b0) differ = 1'b1;
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ****************************************
    // sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge clock);
        #1;
        reset = 1'b0;
        read_reg(FSG_ADDR_CONTROL, 8'h00, "control reset");
        read_reg(FSG_ADDR_RATE_SELECT, {5'h00, FSG_RATE_50MBPS}, "rate");
        read_reg(FSG_ADDR_GPIO_ROUTE_A, 8'h00, "route reset");
        read_reg(8'h30, FSG_READ_UNMAPPED, "unmapped");
        write_reg(FSG_ADDR_HIGH_UPPER, 8'h00);
        write_reg(FSG_ADDR_HIGH_LOWER, 8'h02);
        write_reg(FSG_ADDR_LOW_UPPER, 8'h00);
        write_reg(FSG_ADDR_LOW_LOWER, 8'h03);
        read_reg(FSG_ADDR_HIGH_LOWER, 8'h02, "high lower");
        write_reg(FSG_ADDR_CONTROL, 8'h01);
        watch(150, 0);
        check("unrouted slots", 16'h0000, {15'h0, differ});
        write_reg(FSG_ADDR_GPIO_ROUTE_A, 8'hAA);
        width(1'b1, n);
        check("high width", 16'(3 * T), 16'(n));
        width(1'b0, n);
        check("low width", 16'(4 * T), 16'(n));
        repeat (3) @(posedge clock);
        #1;
        check("remote high", 16'(3 * T), high_len);
        check("remote low", 16'(4 * T), low_len);
        check("slots off", 16'h0000, {4'h0, backchan_gpio_slot[1],
            2'b00, backchan_gpio_slot[0][3:2]});
        write_reg(FSG_ADDR_PORT_SELECT, 8'h02);
        write_reg(FSG_ADDR_GPIO_ROUTE_A, 8'hAA);
        write_reg(FSG_ADDR_PORT_SELECT, 8'h01);
        watch(200, 1);
        check("port skew", 16'h0000, {15'h0, differ});
        write_reg(FSG_ADDR_CONTROL, 8'h03);
        width(1'b1, n);
        check("square high", 16'(3 * T), 16'(n));
        width(1'b0, n);
        check("square low", 16'(3 * T), 16'(n));
        write_reg(FSG_ADDR_CONTROL, 8'h00);
        repeat (2) @(posedge clock);
        watch(100, 2);
        check("disabled", 16'h0000, {15'h0, differ});
        write_reg(FSG_ADDR_CONTROL, 8'h05);
        repeat (2) @(posedge clock);
        #1;
        check("initial level", 16'h0001, {15'h0, frame_sync});
        write_reg(FSG_ADDR_CONTROL, 8'h00);
        write_reg(FSG_ADDR_RATE_SELECT, 8'h05);
        read_reg(FSG_ADDR_RATE_SELECT, 8'h05, "rate slow");
        write_reg(FSG_ADDR_CONTROL, 8'h01);
        width(1'b1, n);
        check("slow high", 16'(6 * T), 16'(n));
        // port 1 still at the fast rate, so its tick gives the short width
        write_reg(FSG_ADDR_CONTROL, 8'h11);
        width(1'b1, n);
        check("port1 tick high", 16'(3 * T), 16'(n));
        write_reg(FSG_ADDR_RATE_SELECT, {5'h00, FSG_RATE_50MBPS});
        write_reg(FSG_ADDR_CONTROL, 8'h00);
        for (int i = 0; i < FSG_PIN_COUNT; i++) begin
            write_reg(FSG_ADDR_CONTROL,
                {4'(FSG_SOURCE_PIN_FIRST + i), 4'h0});
            gpio_in = ~(7'(1) << i);
            repeat (2 * T) @(posedge clock);
            #1;
            check("other pins", 16'h0000, {15'h0, frame_sync});
            gpio_in = 7'(1) << i;
            wait_fs(1'b1, 4 * T, n);
            check("relay delay", 16'h0001, 16'(n <= T + 3));
        end
        stop_test;
    end

    initial begin
        #(40 * 30000);
        miscompares++;
        stop_test;
    end
endmodule
`default_nettype wire
